// ### core/mfs_switch.sv
// Multiple-function light switch: pulse switch with off-delay or permanent light
// What this block does
// - Rising trigger edge while the switch is off sets the output.
// - Trigger held for the permanent-light time gives permanent light, no off-delay.
// - Trigger falling before that time starts the off-delay with elapsed time counting.
// - Output clears when elapsed time equals the off-delay value.
// - Optional warning clears output for its length at off-delay minus lead time.
// - A further trigger while output is active clears output and timing.
// - Reset input clears elapsed time and forces output low.
// - Retentive blocks keep output and time over power loss, others return to defaults.
// - Each time comes from a fixed value or another block's live value, selectable.
`timescale 1ns/1ps
module mfs_switch
   import mfs_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Evaluation strobe, one program cycle
   input  wire logic                     eval_en,
   // Function inputs, from logic on this clock
   input  wire logic                     trigger,
   input  wire logic                     reset_in,
   // Retention and power-fail restore
   input  wire logic                     retentive,
   input  wire logic                     power_restore,
   input  wire logic                     saved_out,
   input  wire logic [TIME_W-1:0]        saved_time,
   // Timebase selects
   input  wire logic [1:0]               delay_tb_sel,
   input  wire logic [1:0]               perm_tb_sel,
   // Fixed times
   input  wire logic [TIME_W-1:0]        off_delay_fix,
   input  wire logic [TIME_W-1:0]        perm_time_fix,
   input  wire logic [TIME_W-1:0]        prewarn_lead_fix,
   input  wire logic [TIME_W-1:0]        prewarn_length_fix,
   input  wire logic                     prewarn_en,
   // Live sources from other blocks
   input  wire logic [N_BLK*TIME_W-1:0]  blk_values,
   input  wire logic [3:0]               use_blk,
   input  wire logic [BLK_W-1:0]         off_delay_blk,
   input  wire logic [BLK_W-1:0]         perm_time_blk,
   input  wire logic [BLK_W-1:0]         prewarn_lead_blk,
   input  wire logic [BLK_W-1:0]         prewarn_length_blk,
   // Results
   output logic                          switch_out,
   output logic [TIME_W-1:0]             elapsed_time,
   output logic                          perm_mode
);

   typedef struct packed {
      mfs_state_t        st;
      logic              trg_prev;
      logic              out;
      logic [TIME_W-1:0] elapsed;
      logic [TIME_W-1:0] hold;
      logic [TB_W-1:0]   dly_div;
      logic [TB_W-1:0]   prm_div;
   } mfs_regs_t;

   mfs_regs_t s_q, s_d;

   logic [TIME_W-1:0] par [4];
   logic [TIME_W-1:0] fix [4];
   logic [BLK_W-1:0]  sel [4];
   assign fix = '{off_delay_fix, perm_time_fix, prewarn_lead_fix, prewarn_length_fix};
   assign sel = '{off_delay_blk, perm_time_blk, prewarn_lead_blk, prewarn_length_blk};

   // Each time picks a fixed figure or another block's live value
   for (genvar i = 0; i < 4; i++) begin : g_par
      assign par[i] = use_blk[i] ? blk_values[sel[i]*TIME_W +: TIME_W] : fix[i];
   end

   function automatic logic [TB_W-1:0] tb_len(input logic [1:0] s);
      unique case (s)
         TB_SEL_10MS: tb_len = TB_W'(TB_10MS_CYC);
         TB_SEL_1S:   tb_len = TB_W'(TB_1S_CYC);
         default:     tb_len = TB_W'(1);
      endcase
   endfunction : tb_len

   logic dly_tick, prm_tick, rise, fall;
   logic [TIME_W-1:0] warn_start, warn_end;
   // Off-delay, lead and length share one timebase so the window arithmetic is valid
   assign dly_tick   = (s_q.dly_div >= tb_len(delay_tb_sel) - TB_W'(1));
   assign prm_tick   = (s_q.prm_div >= tb_len(perm_tb_sel) - TB_W'(1));
   assign rise       = trigger && !s_q.trg_prev;
   assign fall       = !trigger && s_q.trg_prev;
   assign warn_start = (par[0] > par[2]) ? par[0] - par[2] : TIME_RST;
   assign warn_end   = warn_start + par[3];

   // One gap test shared by delay entry, counting and restore so all three agree
   function automatic logic in_gap(input logic [TIME_W-1:0] e);
      return prewarn_en && e >= warn_start && e < warn_end && e < par[0];
   endfunction : in_gap

   always_comb begin
      s_d = s_q;
      if (power_restore) begin
         // Power return: retentive keeps saved state, otherwise defaults
         s_d.st       = MFS_OFF;
         s_d.out      = 1'b0;
         s_d.elapsed  = retentive ? saved_time : TIME_RST;
         s_d.trg_prev = 1'b0;
         s_d.hold     = TIME_RST;
         s_d.dly_div  = '0;
         s_d.prm_div  = '0;
         // A saved time short of the end resumes the delay; one already at the end comes back off
         if (retentive && saved_out && saved_time < par[0]) begin
            s_d.st  = MFS_DELAY;
            s_d.out = !in_gap(saved_time);
         end
      end else if (eval_en) begin
         s_d.trg_prev = trigger;
         s_d.dly_div  = dly_tick ? '0 : s_q.dly_div + TB_W'(1);
         s_d.prm_div  = prm_tick ? '0 : s_q.prm_div + TB_W'(1);
         if (reset_in) begin
            // Reset beats any trigger edge seen in the same cycle
            s_d.st      = MFS_OFF;
            s_d.out     = 1'b0;
            s_d.elapsed = TIME_RST;
            s_d.hold    = TIME_RST;
         end else begin
            unique case (s_q.st)
               MFS_OFF: begin
                  if (rise) begin
                     s_d.st      = MFS_HOLD;
                     s_d.out     = 1'b1;
                     s_d.hold    = TIME_RST;
                     s_d.elapsed = TIME_RST;
                     s_d.prm_div = '0;
                  end
               end
               MFS_HOLD: begin
                  if (fall) begin
                     s_d.st      = MFS_DELAY;
                     s_d.elapsed = TIME_RST;
                     s_d.dly_div = '0;
                     // A zero delay has already run out on entry
                     s_d.out     = !in_gap(TIME_RST) && par[0] != TIME_RST;
                  end else if (prm_tick) begin
                     s_d.hold = s_q.hold + TIME_W'(1);
                     if (s_q.hold + TIME_W'(1) >= par[1]) begin
                        s_d.st = MFS_PERM;
                     end
                  end
               end
               MFS_DELAY: begin
                  if (rise) begin
                     s_d.st      = MFS_OFF;
                     s_d.out     = 1'b0;
                     s_d.elapsed = TIME_RST;
                  end else if (s_q.elapsed >= par[0]) begin
                     s_d.st  = MFS_OFF;
                     s_d.out = 1'b0;
                  end else begin
                     if (dly_tick) begin
                        s_d.elapsed = s_q.elapsed + TIME_W'(1);
                     end
                     // Warning gap sits inside the delay; restored once its length is over
                     s_d.out = !in_gap(s_d.elapsed);
                     if (s_d.elapsed >= par[0]) begin
                        s_d.st  = MFS_OFF;
                        s_d.out = 1'b0;
                     end
                  end
               end
               MFS_PERM: begin
                  if (rise) begin
                     s_d.st      = MFS_OFF;
                     s_d.out     = 1'b0;
                     s_d.elapsed = TIME_RST;
                  end
               end
               default: s_d.st = MFS_OFF;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '{st: MFS_OFF, trg_prev: 1'b0, out: 1'b0, elapsed: TIME_RST,
                  hold: TIME_RST, dly_div: '0, prm_div: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign switch_out   = s_q.out;
   assign elapsed_time = s_q.elapsed;
   assign perm_mode    = s_q.st == MFS_PERM;

   // Checks
   property p_rise_sets;
      @(posedge clk) disable iff (!rst_n)
      (eval_en && !reset_in && !power_restore && s_q.st == MFS_OFF && rise) |=> switch_out;
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rise did not set output");

   property p_reset_clears;
      @(posedge clk) disable iff (!rst_n)
      (eval_en && reset_in && !power_restore) |=> (!switch_out && elapsed_time == TIME_RST);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset left output or time");

   property p_perm_holds;
      @(posedge clk) disable iff (!rst_n)
      (perm_mode && !(eval_en && (rise || reset_in)) && !power_restore) |=> (perm_mode && switch_out);
   endproperty
   a_perm_holds: assert property (p_perm_holds) else $error("permanent light dropped");

   property p_fall_delay;
      @(posedge clk) disable iff (!rst_n)
      (eval_en && !reset_in && !power_restore && s_q.st == MFS_HOLD && fall) |=> s_q.st == MFS_DELAY;
   endproperty
   a_fall_delay: assert property (p_fall_delay) else $error("fall did not start delay");

   property p_expire;
      @(posedge clk) disable iff (!rst_n)
      (s_q.st == MFS_DELAY && eval_en && !power_restore
       && (elapsed_time >= par[0] || (dly_tick && elapsed_time + TIME_W'(1) >= par[0]))) |=> !switch_out;
   endproperty
   a_expire: assert property (p_expire) else $error("output not cleared at delay end");

   property p_retrig_clears;
      @(posedge clk) disable iff (!rst_n)
      (eval_en && !reset_in && !power_restore && (s_q.st == MFS_DELAY || perm_mode) && rise)
         |=> (!switch_out && s_q.st == MFS_OFF);
   endproperty
   a_retrig_clears: assert property (p_retrig_clears) else $error("retrigger did not clear");

   property p_warn_gap;
      @(posedge clk) disable iff (!rst_n)
      (s_q.st == MFS_DELAY && prewarn_en && elapsed_time >= warn_start && elapsed_time < warn_end)
         |-> !switch_out;
   endproperty
   a_warn_gap: assert property (p_warn_gap) else $error("output high inside warning gap");

   property p_restore;
      @(posedge clk) disable iff (!rst_n)
      (power_restore && !retentive) |=> (!switch_out && elapsed_time == TIME_RST);
   endproperty
   a_restore: assert property (p_restore) else $error("non-retentive restore kept state");

   c_perm:  cover property (@(posedge clk) disable iff (!rst_n) $rose(perm_mode));
   c_delay: cover property (@(posedge clk) disable iff (!rst_n) s_q.st == MFS_DELAY ##1 s_q.st == MFS_OFF);
   c_warn:  cover property (@(posedge clk) disable iff (!rst_n) s_q.st == MFS_DELAY && $fell(switch_out));
endmodule : mfs_switch

// ### common/mfs_pkg.sv
// Package for the multiple-function light switch: widths, timebases, source selects, states
package mfs_pkg;
   localparam int unsigned TIME_W      = 16;
   localparam int unsigned BLK_W       = 4;
   localparam int unsigned N_BLK       = 16;
   localparam int unsigned CLK_MHZ     = 250;
   // Timebase tick lengths in ns
   localparam int unsigned TB_10MS_NS  = 10000000;
   localparam int unsigned TB_1S_NS    = 1000000000;
   localparam int unsigned TB_CLK_NS   = 4;
   localparam int unsigned TB_10MS_CYC = TB_10MS_NS / TB_CLK_NS;
   localparam int unsigned TB_1S_CYC   = TB_1S_NS / TB_CLK_NS;
   localparam int unsigned TB_W        = 28;
   localparam logic [1:0]  TB_SEL_CYC  = 2'h0;
   localparam logic [1:0]  TB_SEL_10MS = 2'h1;
   localparam logic [1:0]  TB_SEL_1S   = 2'h2;
   localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;

   typedef enum logic [3:0] {
      MFS_OFF   = 4'h1,
      MFS_HOLD  = 4'h2,
      MFS_DELAY = 4'h4,
      MFS_PERM  = 4'h8
   } mfs_state_t;
endpackage : mfs_pkg

// ### test/mfs_blk_model.sv
// Model of the neighbouring blocks whose live values feed the switch
`timescale 1ns/1ps
module mfs_blk_model
   import mfs_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Live block values
   output logic [N_BLK*TIME_W-1:0]     blk_values
);
   // Same units as the fixed times; block n holds 8 + 2n, kept above the bench's check margins
   always_ff @(posedge clk) begin
      for (int n = 0; n < N_BLK; n++) begin
         blk_values[n*TIME_W +: TIME_W] <= rst_n ? TIME_W'(8 + 2 * n) : TIME_RST;
      end
   end
endmodule : mfs_blk_model

// ### test/tb_top.sv
// Self-checking bench for the multiple-function light switch
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top
   import mfs_pkg::*;
;
   logic                    clk, rst_n, eval_en, trigger, reset_in, retentive, power_restore, saved_out;
   logic                    prewarn_en, switch_out, perm_mode;
   logic [TIME_W-1:0]       saved_time, off_delay_fix, perm_time_fix, lead_fix, len_fix, elapsed_time;
   logic [3:0]              use_blk;
   logic [BLK_W-1:0]        off_delay_blk, perm_time_blk;
   logic [1:0]              delay_tb_sel, perm_tb_sel;
   logic [N_BLK*TIME_W-1:0] blk_values;
   int                      fails = 0, check_count = 0, seed = 90571, t, n;

   mfs_blk_model i_mfs_blk_model (.clk(clk), .rst_n(rst_n), .blk_values(blk_values));
   mfs_switch i_mfs_switch (
      .clk(clk), .rst_n(rst_n), .eval_en(eval_en), .trigger(trigger), .reset_in(reset_in),
      .retentive(retentive), .power_restore(power_restore), .saved_out(saved_out), .saved_time(saved_time),
      .delay_tb_sel(delay_tb_sel), .perm_tb_sel(perm_tb_sel),
      .off_delay_fix(off_delay_fix), .perm_time_fix(perm_time_fix), .prewarn_lead_fix(lead_fix),
      .prewarn_length_fix(len_fix), .prewarn_en(prewarn_en), .blk_values(blk_values), .use_blk(use_blk),
      .off_delay_blk(off_delay_blk), .perm_time_blk(perm_time_blk), .prewarn_lead_blk(4'h0),
      .prewarn_length_blk(4'h0), .switch_out(switch_out), .elapsed_time(elapsed_time), .perm_mode(perm_mode));

   function automatic logic [TIME_W-1:0] blk_val(input int b);
      return TIME_W'(8 + 2 * b);
   endfunction : blk_val
   task automatic step(input int c);
      repeat (c) @(posedge clk);
   endtask : step
   // Trigger high for hi evaluated edges, then low
   task automatic fire(input int hi);
      @(posedge clk) trigger <= 1'b1;
      step(hi);
      trigger <= 1'b0;
   endtask : fire
   // Bounded wait for the elapsed count; a stuck count falls through to the check
   task automatic wait_el(input int v);
      for (int i = 0; i < 200 && elapsed_time !== TIME_W'(v); i++) begin
         @(posedge clk);
         #1;
      end
   endtask : wait_el
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      fails++;
      finish_test;
   end
   initial begin
      {rst_n, eval_en, trigger, reset_in, retentive, power_restore, saved_out, prewarn_en} = 8'h40;
      saved_time = '0;
      off_delay_fix = 16'h0014;
      perm_time_fix = 16'h0028;
      lead_fix = 16'h0014;
      len_fix = 16'h0008;
      use_blk = 4'h0;
      off_delay_blk = '0;
      perm_time_blk = '0;
      // All times of one switch run on the one-tick timebase
      delay_tb_sel = TB_SEL_CYC;
      perm_tb_sel = TB_SEL_CYC;
      step(6);
      rst_n <= 1'b1;
      step(1);
      #1 `CHK("reset out", 1'b0, switch_out);
      // Random off-delays, odd passes take the time from a neighbouring block
      for (int i = 0; i < 6; i++) begin
         n = $random(seed) & 15;
         t = i[0] ? blk_val(n) : 10 + ($random(seed) & 31);
         @(posedge clk);
         use_blk <= {3'h0, i[0]};
         off_delay_blk <= n[BLK_W-1:0];
         off_delay_fix <= t[TIME_W-1:0];
         fire(3);
         #1 `CHK("pulse out", 1'b1, switch_out);
         step(t - 4);
         #1 `CHK("delay out", 1'b1, switch_out);
         `CHK("delay perm", 1'b0, perm_mode);
         `CHK("elapsed", 1'b1, elapsed_time >= t - 7 && elapsed_time <= t - 3);
         step(8);
         #1 `CHK("off out", 1'b0, switch_out);
      end
      // Warning gap covers elapsed 20 to 27 of a 40 count
      @(posedge clk);
      use_blk <= 4'h0;
      off_delay_fix <= 16'h0028;
      prewarn_en <= 1'b1;
      fire(3);
      wait_el(24);
      `CHK("warn gap", 1'b0, switch_out);
      wait_el(31);
      `CHK("warn end", 1'b1, switch_out);
      step(20);
      prewarn_en <= 1'b0;
      fire(3);
      step(4);
      trigger <= 1'b1;
      step(2);
      #1 `CHK("retrig out", 1'b0, switch_out);
      `CHK("retrig time", 16'h0000, elapsed_time);
      // Permanent-light time taken live from block 2; the fixed 40 would never be reached
      @(posedge clk) perm_time_blk <= 4'h2;
      use_blk <= 4'h2;
      trigger <= 1'b0;
      fire(20);
      step(1);
      #1 `CHK("perm mode", 1'b1, perm_mode);
      step(60);
      #1 `CHK("perm out", 1'b1, switch_out);
      fire(1);
      step(1);
      #1 `CHK("perm clear", 1'b0, switch_out);
      `CHK("perm off", 1'b0, perm_mode);
      fire(3);
      step(4);
      reset_in <= 1'b1;
      step(1);
      reset_in <= 1'b0;
      step(1);
      #1 `CHK("rst out", 1'b0, switch_out);
      `CHK("rst time", 16'h0000, elapsed_time);
      @(posedge clk) {reset_in, trigger} <= 2'h3;
      step(1);
      {reset_in, trigger} <= 2'h0;
      step(1);
      #1 `CHK("rst wins", 1'b0, switch_out);
      // Slow timebases: neither hold nor delay may advance within a few dozen cycles
      @(posedge clk) {delay_tb_sel, perm_tb_sel} <= {TB_SEL_10MS, TB_SEL_1S};
      fire(20);
      step(30);
      #1 `CHK("slow perm", 1'b0, perm_mode);
      `CHK("slow time", 16'h0000, elapsed_time);
      `CHK("slow out", 1'b1, switch_out);
      @(posedge clk) {delay_tb_sel, perm_tb_sel, reset_in} <= {TB_SEL_CYC, TB_SEL_CYC, 1'b1};
      step(1);
      reset_in <= 1'b0;
      // Edge raised while evaluation is paused is only seen once it resumes
      @(posedge clk) {eval_en, trigger} <= 2'h1;
      step(4);
      #1 `CHK("paused", 1'b0, switch_out);
      @(posedge clk) eval_en <= 1'b1;
      step(2);
      #1 `CHK("late edge", 1'b1, switch_out);
      @(posedge clk) {reset_in, trigger} <= 2'h2;
      step(1);
      reset_in <= 1'b0;
      for (int r = 0; r < 2; r++) begin
         @(posedge clk) {retentive, saved_out, power_restore} <= {r[0], 2'h3};
         saved_time <= 16'h0005;
         step(1);
         power_restore <= 1'b0;
         step(1);
         #1 `CHK("restore out", r[0], switch_out);
         `CHK("restore time", 1'b1, r ? elapsed_time inside {[5:7]} : elapsed_time == 0);
         @(posedge clk) reset_in <= 1'b1;
         step(1);
         reset_in <= 1'b0;
      end
      finish_test;
   end
endmodule : tb_top
